// File: ssd_pkg.sv
/*
 * shared constants and types for the shift, string and store decoder.
 * assumes a single cpu clock; the fetch unit has already split the
 * opcode into its group and raw fields before handing it over.
 */
package ssd_pkg;

	// widths
	localparam int SSD_CW = 20; // cycle total width
	localparam int SSD_MW = 16; // iteration count width

	// instruction groups handed over by the fetch unit
	typedef enum logic [3:0] {
		OP_ARITH_SHIFT_IMM = 4'h0,
		OP_LOGICAL_SHIFT_IMM = 4'h1,
		OP_ARITH_SHIFT_REG = 4'h2,
		OP_LOGICAL_SHIFT_REG = 4'h3,
		OP_ARITH_SHIFT_L_IMM = 4'h4,
		OP_LOGICAL_SHIFT_L_IMM = 4'h5,
		OP_ARITH_SHIFT_L_REG = 4'h6,
		OP_LOGICAL_SHIFT_L_REG = 4'h7,
		OP_STRING_MOVE_BACKWARD = 4'h8,
		OP_STRING_MOVE_FORWARD = 4'h9,
		OP_STRING_FILL = 4'ha,
		OP_CONTROL_REG_STORE = 4'hb,
		OP_PC_STORE = 4'hc,
		OP_CONTEXT_SAVE = 4'hd,
		OP_EXTENDED_STORE = 4'he,
		OP_NONE = 4'hf
	} ssd_op_t;

	// addressing classes of the general 4-bit operand field
	typedef enum logic [2:0] {
		MODE_DATA_REG = 3'h0,
		MODE_ADDR_REG = 3'h1,
		MODE_INDIRECT = 3'h2,
		MODE_DSP8 = 3'h3,
		MODE_DSP16 = 3'h4,
		MODE_STATIC_DSP16 = 3'h5,
		MODE_ABS16 = 3'h6
	} ssd_mode_t;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} ssd_state_t;

	// general operand field codes
	localparam logic [3:0] FLD_ADDR_FIRST = 4'h4;
	localparam logic [3:0] FLD_IND_FIRST = 4'h6;
	localparam logic [3:0] FLD_DSP8_FIRST = 4'h8;
	localparam logic [3:0] FLD_DSP16_FIRST = 4'hc;
	localparam logic [3:0] FLD_STATIC_DSP16 = 4'he;
	localparam logic [3:0] FLD_ABS16 = 4'hf;
	localparam logic [3:0] FLD_WORD_CNT_CLASH = 4'h1; // word half of count register
	localparam logic [3:0] FLD_BYTE_CNT_CLASH = 4'h3; // count byte register itself
	localparam logic [3:0] FLD_PC_BAD_A = 4'h2;
	localparam logic [3:0] FLD_PC_BAD_B = 4'h3;
	localparam logic [3:0] FLD_PC_BAD_C = 4'h5;
	localparam logic [2:0] CTRL_SRC_NONE = 3'h0;
	localparam logic SIZE_BYTE = 1'b0;
	localparam logic PAIR_LOW = 1'b0; // low_register_pair; 1 is high_register_pair

	// instruction lengths in bytes
	localparam logic [2:0] LEN_SHORT = 3'h2;
	localparam logic [2:0] LEN_EXT_BASE = 3'h5;
	localparam logic [2:0] LEN_CONTEXT = 3'h7;

	// cycle figures: base for register / memory operand, and per iteration
	localparam int CYC_IMM_REG = 1;
	localparam int CYC_IMM_MEM = 2;
	localparam int CYC_CNT_REG = 2;
	localparam int CYC_CNT_MEM = 3;
	localparam int CYC_L_IMM = 3;
	localparam int CYC_L_CNT = 4;
	localparam int CYC_SHIFT_EACH = 1;
	localparam int CYC_MOVE_BASE = 5;
	localparam int CYC_MOVE_EACH = 5;
	localparam int CYC_FILL_BASE = 3;
	localparam int CYC_FILL_EACH = 2;
	localparam int CYC_CTRL_REG = 1;
	localparam int CYC_CTRL_MEM = 2;
	localparam int CYC_PC_REG = 2;
	localparam int CYC_PC_MEM = 3;
	localparam int CYC_CTX_BASE = 11;
	localparam int CYC_CTX_EACH = 2;
	localparam int CYC_EXT_REG = 3;
	localparam int CYC_EXT_MEM = 4;

	// request from the fetch unit
	typedef struct packed {
		ssd_op_t op;
		logic size;                     // 0 byte, 1 word
		logic [3:0] operand;            // general dest / src field
		logic [3:0] short_count_field;  // immediate shift count code
		logic pair_sel;                 // 32-bit register pair select
		logic [2:0] ctrl_src;           // control register source
	} ssd_req_t;

	// decoded instruction for the datapath
	typedef struct packed {
		ssd_op_t op;
		logic size;
		logic [3:0] operand;
		ssd_mode_t mode;
		logic pair_sel;
		logic [2:0] ctrl_src;
		logic shift_left;               // 1 toward msb, 0 toward lsb
		logic [7:0] shift_mag;
		logic [SSD_MW-1:0] iterations;
		logic [2:0] length;
		logic [SSD_CW-1:0] cycles;
	} ssd_dec_t;

endpackage

// File: ssd_operand_dec.sv
/*
 * classifies the general 4-bit operand field: addressing class,
 * memory or register, and displacement bytes that follow.
 * purely combinational, driven from the top decoder's request.
 */
`timescale 1ns/1ps
`default_nettype none

module ssd_operand_dec
	import ssd_pkg::*;
(
	input wire logic [3:0] field_i,
	output ssd_mode_t mode_o,
	output logic is_mem_o,
	output logic [1:0] extra_bytes_o
);

	// code order: data regs, address regs, indirect, dsp8, dsp16, static dsp16, abs16
	always_comb begin
		if (field_i < FLD_ADDR_FIRST) begin
			mode_o = MODE_DATA_REG;
		end else if (field_i < FLD_IND_FIRST) begin
			mode_o = MODE_ADDR_REG;
		end else if (field_i < FLD_DSP8_FIRST) begin
			mode_o = MODE_INDIRECT;
		end else if (field_i < FLD_DSP16_FIRST) begin
			mode_o = MODE_DSP8;
		end else if (field_i == FLD_STATIC_DSP16) begin
			mode_o = MODE_STATIC_DSP16;
		end else if (field_i == FLD_ABS16) begin
			mode_o = MODE_ABS16;
		end else begin
			mode_o = MODE_DSP16;
		end
	end

	// memory operands and the extension bytes they bring
	always_comb begin
		is_mem_o = (field_i >= FLD_IND_FIRST);
		if (field_i >= FLD_DSP16_FIRST) begin
			extra_bytes_o = 2'h2;
		end else if (field_i >= FLD_DSP8_FIRST) begin
			extra_bytes_o = 2'h1;
		end else begin
			extra_bytes_o = 2'h0;
		end
	end

endmodule

`default_nettype wire

// File: ssd_decoder.sv
/*
 * decoder and cycle sequencer for shifts, string moves, string fill,
 * control register / pc store, context save and extended store.
 * assumes the fetch unit presents one predecoded request at a time and
 * the datapath supplies the count byte and the transfer count.
 */
// Behaviour
// - short count codes 0000-0111 mean +1..+8, 1000-1111 mean -1..-8.
// - operand field orders data, address, indirect, dsp8, dsp16, static dsp16, abs16.
// - register-count shifts refuse byte code 0011 and word code 0001.
// - register-count byte/word shifts take 2+m register, 3+m memory cycles.
// - immediate byte/word shifts take 1+m register, 2+m memory cycles.
// - 32-bit arithmetic immediate shift selects low or high pair by one bit.
// - 32-bit register-count shifts are 2 bytes, 4+m cycles, pair select bit.
// - 32-bit logical immediate shift is 2 bytes, 3+m cycles.
// - backward and forward string moves are 2 bytes, 5+5m cycles.
// - string fill is 2 bytes, 3+2m cycles.
// - control register store decodes 3-bit source; code 000 refused.
// - pc store refuses operand codes 0010, 0011 and 0101.
// - context save is 7 bytes, 11+2m cycles.
// - extended store is 5 to 7 bytes as source displacement widens.
`timescale 1ns/1ps
`default_nettype none

module ssd_decoder
	import ssd_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic req_valid_i,
	input wire ssd_req_t req_i,
	input wire logic [7:0] count_byte_register_i,
	input wire logic [SSD_MW-1:0] transfer_count_i,
	output logic req_ready_o,
	output logic start_o,
	output ssd_dec_t dec_o,
	output logic hold_o,
	output logic done_o,
	output logic undef_o
);

	// whole module state
	typedef struct packed {
		ssd_state_t st;
		logic [SSD_CW-1:0] remain;
		ssd_dec_t dec;
		logic ready;
		logic start;
		logic hold;
		logic done;
		logic undef;
	} ssd_regs_t;

	ssd_regs_t r_q;
	ssd_regs_t r_d;
	ssd_dec_t dec_now;
	ssd_mode_t op_mode;
	logic op_is_mem;
	logic [1:0] op_extra;
	logic refused;

	// short count code: bit 3 gives the sign, low bits the magnitude minus one
	function automatic logic [7:0] short_mag(input logic [3:0] code);
		short_mag = {5'h00, code[2:0]} + 8'h01;
	endfunction

	function automatic logic short_left(input logic [3:0] code);
		short_left = ~code[3];
	endfunction

	// magnitude of a signed count byte; -128 gives 128
	function automatic logic [7:0] byte_mag(input logic [7:0] v);
		byte_mag = v[7] ? (8'h00 - v) : v;
	endfunction

	// base plus per-iteration cost
	function automatic logic [SSD_CW-1:0] total(input int base, input int each,
			input logic [SSD_MW-1:0] m);
		total = SSD_CW'(base) + SSD_CW'(each) * SSD_CW'(m);
	endfunction

	ssd_operand_dec u_operand (
		.field_i(req_i.operand),
		.mode_o(op_mode),
		.is_mem_o(op_is_mem),
		.extra_bytes_o(op_extra)
	);

	// decode the request and work out length and cycle total
	always_comb begin
		dec_now = '0;
		refused = 1'b0;
		dec_now.op = req_i.op;
		dec_now.size = req_i.size;
		dec_now.operand = req_i.operand;
		dec_now.mode = op_mode;
		dec_now.pair_sel = req_i.pair_sel;
		dec_now.ctrl_src = req_i.ctrl_src;
		dec_now.length = LEN_SHORT + {1'b0, op_extra};
		case (req_i.op)
			OP_ARITH_SHIFT_IMM, OP_LOGICAL_SHIFT_IMM: begin
				dec_now.shift_left = short_left(req_i.short_count_field);
				dec_now.shift_mag = short_mag(req_i.short_count_field);
				dec_now.iterations = SSD_MW'(dec_now.shift_mag);
				dec_now.cycles = total(op_is_mem ? CYC_IMM_MEM : CYC_IMM_REG,
					CYC_SHIFT_EACH, dec_now.iterations);
			end
			OP_ARITH_SHIFT_REG, OP_LOGICAL_SHIFT_REG: begin
				if (req_i.size == SIZE_BYTE) begin
					refused = (req_i.operand == FLD_BYTE_CNT_CLASH);
				end else begin
					refused = (req_i.operand == FLD_WORD_CNT_CLASH);
				end
				dec_now.shift_left = ~count_byte_register_i[7];
				dec_now.shift_mag = byte_mag(count_byte_register_i);
				dec_now.iterations = SSD_MW'(dec_now.shift_mag);
				dec_now.cycles = total(op_is_mem ? CYC_CNT_MEM : CYC_CNT_REG,
					CYC_SHIFT_EACH, dec_now.iterations);
			end
			OP_ARITH_SHIFT_L_IMM, OP_LOGICAL_SHIFT_L_IMM: begin
				dec_now.mode = MODE_DATA_REG; // pair chosen by pair_sel
				dec_now.length = LEN_SHORT;
				dec_now.shift_left = short_left(req_i.short_count_field);
				dec_now.shift_mag = short_mag(req_i.short_count_field);
				dec_now.iterations = SSD_MW'(dec_now.shift_mag);
				dec_now.cycles = total(CYC_L_IMM, CYC_SHIFT_EACH, dec_now.iterations);
			end
			OP_ARITH_SHIFT_L_REG, OP_LOGICAL_SHIFT_L_REG: begin
				dec_now.mode = MODE_DATA_REG;
				dec_now.length = LEN_SHORT;
				dec_now.shift_left = ~count_byte_register_i[7];
				dec_now.shift_mag = byte_mag(count_byte_register_i);
				dec_now.iterations = SSD_MW'(dec_now.shift_mag);
				dec_now.cycles = total(CYC_L_CNT, CYC_SHIFT_EACH, dec_now.iterations);
			end
			OP_STRING_MOVE_BACKWARD, OP_STRING_MOVE_FORWARD: begin
				dec_now.length = LEN_SHORT;
				dec_now.iterations = transfer_count_i;
				dec_now.cycles = total(CYC_MOVE_BASE, CYC_MOVE_EACH, transfer_count_i);
			end
			OP_STRING_FILL: begin
				dec_now.length = LEN_SHORT;
				dec_now.iterations = transfer_count_i;
				dec_now.cycles = total(CYC_FILL_BASE, CYC_FILL_EACH, transfer_count_i);
			end
			OP_CONTROL_REG_STORE: begin
				refused = (req_i.ctrl_src == CTRL_SRC_NONE);
				dec_now.cycles = total(op_is_mem ? CYC_CTRL_MEM : CYC_CTRL_REG, 0, '0);
			end
			OP_PC_STORE: begin
				refused = (req_i.operand == FLD_PC_BAD_A) || (req_i.operand == FLD_PC_BAD_B)
					|| (req_i.operand == FLD_PC_BAD_C);
				dec_now.cycles = total(op_is_mem ? CYC_PC_MEM : CYC_PC_REG, 0, '0);
			end
			OP_CONTEXT_SAVE: begin
				dec_now.length = LEN_CONTEXT;
				dec_now.iterations = transfer_count_i;
				dec_now.cycles = total(CYC_CTX_BASE, CYC_CTX_EACH, transfer_count_i);
			end
			OP_EXTENDED_STORE: begin
				dec_now.length = LEN_EXT_BASE + {1'b0, op_extra};
				dec_now.cycles = total(op_is_mem ? CYC_EXT_MEM : CYC_EXT_REG, 0, '0);
			end
			default: begin
				refused = 1'b1; // groups outside this decoder
			end
		endcase
	end

	// sequencer: accept, run for the cycle total, then release the pipeline
	always_comb begin
		r_d = r_q;
		r_d.start = 1'b0;
		r_d.done = 1'b0;
		r_d.undef = 1'b0;
		case (r_q.st)
			ST_IDLE: begin
				if (req_valid_i) begin
					if (refused) begin
						r_d.undef = 1'b1; // nothing started
					end else begin
						r_d.dec = dec_now;
						r_d.start = 1'b1;
						r_d.hold = 1'b1;
						r_d.ready = 1'b0;
						r_d.remain = dec_now.cycles - SSD_CW'(1);
						r_d.st = ST_RUN;
					end
				end
			end
			ST_RUN: begin
				if (r_q.remain == '0) begin
					r_d.hold = 1'b0; // whole cycle total counted down
					r_d.done = 1'b1;
					r_d.ready = 1'b1;
					r_d.st = ST_IDLE;
				end else begin
					r_d.remain = r_q.remain - SSD_CW'(1);
				end
			end
			default: begin
				r_d = '0;
				r_d.st = ST_IDLE;
				r_d.ready = 1'b1;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r_q <= '{st: ST_IDLE, ready: 1'b1, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	// outputs straight from the state register
	assign req_ready_o = r_q.ready;
	assign start_o = r_q.start;
	assign dec_o = r_q.dec;
	assign hold_o = r_q.hold;
	assign done_o = r_q.done;
	assign undef_o = r_q.undef;

endmodule

`default_nettype wire

// File: ssd_decoder_sva.sv
/* port checker for the shift, string and store decoder.
 assumes it is bound onto ssd_decoder and sees one clock. */
`timescale 1ns/1ps
`default_nettype none
module ssd_decoder_sva
	import ssd_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic req_valid_i,
	input wire ssd_req_t req_i,
	input wire logic [7:0] count_byte_register_i,
	input wire logic [SSD_MW-1:0] transfer_count_i,
	input wire logic req_ready_o,
	input wire logic start_o,
	input wire ssd_dec_t dec_o,
	input wire logic hold_o,
	input wire logic done_o,
	input wire logic undef_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [SSD_CW-1:0] hold_cnt_q;
	logic take;
	// counts cycles of the current hold, cleared while idle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_cnt_q <= '0;
		end else begin
			hold_cnt_q <= hold_o ? hold_cnt_q + 1'b1 : '0;
		end
	end
	assign take = req_valid_i && req_ready_o;
	answer_once_a: assert property (take |=> start_o ^ undef_o)
		else $error("taken request lacks a single answer");
	undef_quiet_a: assert property (undef_o |-> !hold_o && req_ready_o)
		else $error("refused request started work");
	start_holds_a: assert property (start_o |-> hold_o && !req_ready_o)
		else $error("start without hold");
	hold_ends_a: assert property ($fell(hold_o) |-> done_o && req_ready_o)
		else $error("hold fell without done");
	hold_count_a: assert property (done_o |-> hold_cnt_q == dec_o.cycles)
		else $error("hold length differs from cycle total");
	imm_count_a: assert property (start_o && dec_o.op inside {OP_ARITH_SHIFT_IMM,
		OP_LOGICAL_SHIFT_IMM, OP_ARITH_SHIFT_L_IMM, OP_LOGICAL_SHIFT_L_IMM}
		|-> dec_o.shift_left == !$past(req_i.short_count_field[3])
		&& dec_o.shift_mag == 8'($past(req_i.short_count_field[2:0])) + 8'h1)
		else $error("short count decoded wrongly");
	byte_clash_a: assert property (take && req_i.op inside {OP_ARITH_SHIFT_REG,
		OP_LOGICAL_SHIFT_REG} && ((!req_i.size && req_i.operand == 4'h3)
		|| (req_i.size && req_i.operand == 4'h1)) |=> undef_o)
		else $error("count register clash accepted");
	ctrl_none_a: assert property (take && req_i.op == OP_CONTROL_REG_STORE
		&& req_i.ctrl_src == 3'h0 |=> undef_o)
		else $error("empty control source accepted");
	pc_bad_a: assert property (take && req_i.op == OP_PC_STORE
		&& req_i.operand inside {4'h2, 4'h3, 4'h5} |=> undef_o)
		else $error("bad pc store target accepted");
	ctx_len_a: assert property (start_o && dec_o.op == OP_CONTEXT_SAVE
		|-> dec_o.length == 3'h7 && dec_o.cycles == 20'd11 + {$past(transfer_count_i), 1'b0})
		else $error("context save length or cycles wrong");
	cover property (start_o && dec_o.op == OP_CONTEXT_SAVE);
	cover property (undef_o);
	cover property (done_o ##1 start_o);
endmodule
bind ssd_decoder ssd_decoder_sva u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .count_byte_register_i(count_byte_register_i),
	.transfer_count_i(transfer_count_i), .req_ready_o(req_ready_o), .start_o(start_o),
	.dec_o(dec_o), .hold_o(hold_o), .done_o(done_o), .undef_o(undef_o));
`default_nettype wire

// File: ssd_fetch_model.sv
/* fetch unit and datapath stand-in: presents one request and its operands.
 assumes issue is called just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module ssd_fetch_model
	import ssd_pkg::*;
(
	input wire logic clk_i,
	input wire logic req_ready_i,
	output logic req_valid_o,
	output ssd_req_t req_o,
	output logic [7:0] count_o,
	output logic [SSD_MW-1:0] m_o
);
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
		count_o = '0;
		m_o = '0;
	end
	// hold the request until ready is seen at an edge; it stays up until withdrawn
	task automatic issue(input ssd_req_t r, input logic [7:0] c, input logic [SSD_MW-1:0] m);
		req_valid_o = 1'b1;
		req_o = r;
		count_o = c;
		m_o = m;
		do @(posedge clk_i); while (req_ready_i !== 1'b1);
		#1;
	endtask
	// drop valid and scramble the bus, so a decoder that re-reads it is caught
	task automatic withdraw;
		req_valid_o = 1'b0;
		req_o = ~req_o;
		count_o = ~count_o;
		m_o = ~m_o;
	endtask
endmodule
`default_nettype wire

// File: ssd_decoder_tb.sv
/* self-checking bench for the decoder: table sweeps plus seeded random requests.
 assumes the fetch model drives all request inputs. */
`timescale 1ns/1ps
`default_nettype none
module ssd_decoder_tb
	import ssd_pkg::*;
;
	logic clk_i, arst_n_i, req_valid, ready, start, hold, done, undef;
	ssd_req_t req, r;
	ssd_dec_t dec;
	logic [7:0] cnt;
	logic [SSD_MW-1:0] m;
	int num_errors = 0;
	int cmp_count = 0;
	int i;
	ssd_fetch_model u_fm (.clk_i(clk_i), .req_ready_i(ready), .req_valid_o(req_valid),
		.req_o(req), .count_o(cnt), .m_o(m));
	ssd_decoder u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid),
		.req_i(req), .count_byte_register_i(cnt), .transfer_count_i(m), .req_ready_o(ready),
		.start_o(start), .dec_o(dec), .hold_o(hold), .done_o(done), .undef_o(undef));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// expectations
	function automatic int ext(logic [3:0] f);
		return f < 4'h8 ? 0 : (f < 4'hc ? 1 : 2);
	endfunction
	function automatic int mag(ssd_req_t q, logic [7:0] c);
		return q.op[1] ? (c[7] ? 256 - c : c) : q.short_count_field[2:0] + 1;
	endfunction
	function automatic bit refused(ssd_req_t q);
		return q.op == OP_NONE || (q.op == OP_CONTROL_REG_STORE && q.ctrl_src == 3'h0)
			|| (q.op == OP_PC_STORE && q.operand inside {4'h2, 4'h3, 4'h5})
			|| (q.op inside {OP_ARITH_SHIFT_REG, OP_LOGICAL_SHIFT_REG}
			&& q.operand == (q.size ? 4'h1 : 4'h3));
	endfunction
	function automatic int cyc(ssd_req_t q, logic [7:0] c, int t);
		int mm;
		mm = q.operand >= 4'h6;
		case (q.op)
			OP_ARITH_SHIFT_IMM, OP_LOGICAL_SHIFT_IMM: return 1 + mm + mag(q, c);
			OP_ARITH_SHIFT_REG, OP_LOGICAL_SHIFT_REG: return 2 + mm + mag(q, c);
			OP_ARITH_SHIFT_L_IMM, OP_LOGICAL_SHIFT_L_IMM: return 3 + mag(q, c);
			OP_ARITH_SHIFT_L_REG, OP_LOGICAL_SHIFT_L_REG: return 4 + mag(q, c);
			OP_STRING_MOVE_BACKWARD, OP_STRING_MOVE_FORWARD: return 5 + 5 * t;
			OP_STRING_FILL: return 3 + 2 * t;
			OP_CONTROL_REG_STORE: return 1 + mm;
			OP_PC_STORE: return 2 + mm;
			OP_CONTEXT_SAVE: return 11 + 2 * t;
			default: return 3 + mm;
		endcase
	endfunction
	function automatic int len(ssd_req_t q);
		if (q.op == OP_CONTEXT_SAVE) return 7;
		if (q.op == OP_EXTENDED_STORE) return 5 + ext(q.operand);
		if (q.op <= OP_LOGICAL_SHIFT_REG || q.op inside {OP_CONTROL_REG_STORE, OP_PC_STORE})
			return 2 + ext(q.operand);
		return 2;
	endfunction
	// iterations the datapath is told to run
	function automatic int its(ssd_req_t q, logic [7:0] c, int t);
		if (q.op <= OP_LOGICAL_SHIFT_L_REG) return mag(q, c);
		if (q.op inside {OP_STRING_MOVE_BACKWARD, OP_STRING_MOVE_FORWARD, OP_STRING_FILL,
			OP_CONTEXT_SAVE}) return t;
		return 0;
	endfunction
	function automatic logic [2:0] mode(logic [3:0] f);
		return f < 4'h4 ? 3'h0 : f < 4'h6 ? 3'h1 : f < 4'h8 ? 3'h2 : f < 4'hc ? 3'h3
			: f < 4'he ? 3'h4 : f == 4'he ? 3'h5 : 3'h6;
	endfunction
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// one instruction through the model, then decode fields and hold length
	task automatic run(input ssd_req_t q, input logic [7:0] c, input int t);
		int n;
		n = 0;
		u_fm.issue(q, c, 16'(t));
		chk({start, undef}, {!refused(q), refused(q)});
		if (refused(q)) begin
			// either offer the next request at once or idle across one edge
			if ($urandom_range(0, 1) == 1) begin
				u_fm.withdraw();
				@(posedge clk_i);
				#1;
			end
		end else begin
			u_fm.withdraw();
			chk(dec.length, len(q));
			chk(dec.cycles, 20'(cyc(q, c, t)));
			chk(dec.iterations, 20'(its(q, c, t)));
			chk({dec.op, dec.operand}, {q.op, q.operand});
			chk({dec.size, dec.ctrl_src}, {q.size, q.ctrl_src});
			if (q.op <= OP_LOGICAL_SHIFT_REG || q.op >= OP_CONTROL_REG_STORE && q.op != OP_CONTEXT_SAVE)
				chk(dec.mode, mode(q.operand));
			if (q.op <= OP_LOGICAL_SHIFT_L_REG)
				chk({dec.shift_left, dec.shift_mag}, {!(q.op[1] ? c[7] : q.short_count_field[3]),
					8'(mag(q, c))});
			if (q.op[3:2] == 2'b01)
				chk(dec.pair_sel, q.pair_sel);
			while (hold === 1'b1 && n < 400) begin
				n++;
				@(posedge clk_i);
				#1;
			end
			chk({done, ready}, 2'b11);
			chk(20'(n), 20'(cyc(q, c, t)));
			// back to back from the done cycle, or one idle edge first
			repeat ($urandom_range(0, 1)) begin
				@(posedge clk_i);
				#1;
			end
		end
	endtask
	task automatic complete_run;
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#500_000;
		num_errors++;
		complete_run;
	end
	// sweeps of every code, count register corners, then random requests
	initial begin
		void'($urandom(13070));
		arst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		for (i = 0; i < 16; i++) begin
			r = '0;
			r.short_count_field = i[3:0];
			r.op = OP_LOGICAL_SHIFT_IMM;
			run(r, 8'h0, 0);
			r.operand = i[3:0];
			r.op = OP_PC_STORE;
			run(r, 8'h0, 0);
			r.op = OP_EXTENDED_STORE;
			r.size = i[0];
			run(r, 8'h0, 0);
			r.op = OP_CONTROL_REG_STORE;
			r.ctrl_src = i[2:0];
			run(r, 8'h0, 0);
			r.op = ssd_op_t'(i);
			run(r, 8'h80, 0);
		end
		r = '0;
		r.op = OP_ARITH_SHIFT_REG;
		r.operand = 4'h3;
		run(r, 8'h80, 0);
		r.size = 1'b1;
		run(r, 8'h80, 0);
		r.operand = 4'h1;
		run(r, 8'h7f, 0);
		repeat (200) begin
			r = ssd_req_t'($urandom);
			run(r, 8'($urandom), $urandom_range(0, 40));
		end
		complete_run;
	end
endmodule
`default_nettype wire
